//--- verilog/insn_tail_pkg.sv
// Constants, encodings and timing for the instruction decode tail.
package insn_tail_pkg;
    localparam logic [7:0] OP_TWO_BYTE = 8'h0F;
    localparam logic [7:0] OP_SET_CARRY = 8'hF9;
    localparam logic [7:0] OP_SET_DIR = 8'hFD;
    localparam logic [7:0] OP_SET_INT = 8'hFB;
    localparam logic [7:0] OP_FPU_WAIT = 8'h9B;
    localparam logic [7:0] OP2_SAVE_SEG = 8'h78;
    localparam logic [7:0] OP2_SAVE_LDT = 8'h7A;
    localparam logic [7:0] OP2_SAVE_TASK = 8'h7C;
    localparam logic [7:0] OP2_VERIFY = 8'h00;
    localparam logic [7:0] OP2_FLUSH = 8'h09;
    localparam logic [7:0] OP2_MSR_WRITE = 8'h30;
    localparam logic [6:0] OP2_EXCHANGE_ADD_INSN_HI = 7'h60;
    localparam logic [2:0] REG_VERIFY_RD = 3'h4;
    localparam logic [2:0] REG_VERIFY_WR = 3'h5;
    localparam logic [2:0] REG_SUB = 3'h5;
    localparam logic [2:0] REG_XOR = 3'h6;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [7:0] VEC_INVALID_OP = 8'h06;
    localparam logic [7:0] VEC_STACK = 8'h0C;
    localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
    localparam logic [16:0] REAL_SEG_LIMIT = 17'h0FFFF;
    localparam logic [7:0] CYC_SET_CARRY = 8'h01;
    localparam logic [7:0] CYC_SET_DIR = 8'h04;
    localparam logic [7:0] CYC_SET_INT = 8'h06;
    localparam logic [7:0] CYC_ALU = 8'h01;
    localparam logic [7:0] CYC_SAVE = 8'h14;
    localparam logic [7:0] CYC_SAVE_TASK = 8'h15;
    localparam logic [7:0] CYC_VERIFY = 8'h08;
    localparam logic [7:0] CYC_WAIT = 8'h01;
    localparam logic [7:0] CYC_FLUSH = 8'h17;
    localparam logic [7:0] CYC_MSR = 8'h01;
    localparam logic [7:0] CYC_SWAP = 8'h02;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [2:0] ALU_NONE = 3'h0;
    localparam logic [2:0] ALU_SUB = 3'h1;
    localparam logic [2:0] ALU_TEST = 3'h2;
    localparam logic [2:0] ALU_XOR = 3'h3;
    localparam logic [2:0] ALU_ADD = 3'h4;
endpackage

//--- verilog/x86_insn_decode_tail.sv
// Decode and execution timing of the instruction tail of the integer core.
`timescale 1ns/100ps
module x86_insn_decode_tail
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic issue_valid,
    input wire logic [7:0] op_byte0,
    input wire logic [7:0] op_byte1,
    input wire logic [7:0] op_modrm,
    input wire logic [31:0] operand_a,
    input wire logic [31:0] operand_b,
    input wire logic operand_wide,
    input wire logic protected_mode,
    input wire logic [1:0] current_privilege,
    input wire logic [1:0] io_privilege,
    input wire logic smi_enabled,
    input wire logic [31:0] smm_region_reg,
    input wire logic smm_access_bit,
    input wire logic in_smi_handler,
    input wire logic [16:0] operand_end,
    input wire logic operand_is_mem,
    input wire logic operand_on_stack,
    input wire logic seg_readable,
    input wire logic seg_writable,
    input wire logic fpu_busy,
    input wire logic flush_done,
    input wire logic [5:0] flags_in,
    output logic busy,
    output logic done,
    output logic [5:0] flags_out,
    output logic flags_we,
    output logic int_enable_set,
    output logic direction_set,
    output logic [31:0] result,
    output logic result_we,
    output logic fault,
    output logic [7:0] fault_vector,
    output logic bus_lock,
    output logic flush_req,
    output logic msr_write,
    output logic save_req,
    output logic [1:0] save_kind
);
    import insn_tail_pkg::*;

    // Flag vector order: overflow, sign, zero, aux, parity, carry.
    localparam int FO = 5;
    localparam int FS = 4;
    localparam int FZ = 3;
    localparam int FA = 2;
    localparam int FC = 0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_WAIT_FPU = 4'b0100,
        ST_FLUSH = 4'b1000
    } state_t;

    typedef struct packed {
        state_t st;
        logic [7:0] cnt;
        logic busy;
        logic done;
        logic [5:0] flags;
        logic flags_we;
        logic int_set;
        logic dir_set;
        logic [31:0] res;
        logic res_we;
        logic fault;
        logic [7:0] vec;
        logic lock;
        logic flush;
        logic msr;
        logic save;
        logic [1:0] skind;
    } core_t;

    core_t cur_reg, cur_next;

    function automatic logic even_parity(input logic [7:0] v);
        even_parity = ~^v;
    endfunction

    function automatic logic [5:0] logic_flags(input logic [31:0] r,
                                               input logic w,
                                               input logic [5:0] f);
        logic [5:0] o;
        o = f;
        o[FO] = 1'b0;
        o[FC] = 1'b0;
        o[FS] = w ? r[31] : r[15];
        o[FZ] = w ? (r == 32'h00000000) : (r[15:0] == 16'h0000);
        o[1] = even_parity(r[7:0]);
        logic_flags = o;
    endfunction

    function automatic logic [5:0] arith_flags(input logic [31:0] a,
                                               input logic [31:0] b,
                                               input logic sub,
                                               input logic w);
        logic [32:0] s;
        logic [31:0] bb;
        logic [5:0] o;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {32'h00000000, sub};
        o = logic_flags(s[31:0], w, 6'h00);
        if (w)
        begin
            o[FO] = (a[31] == bb[31]) && (s[31] != a[31]);
            o[FC] = s[32] ^ sub;
        end
        else
        begin
            o[FO] = (a[15] == bb[15]) && (s[15] != a[15]);
            o[FC] = (a[16] ^ bb[16] ^ s[16]) ^ sub;
        end
        o[FA] = a[4] ^ bb[4] ^ s[4] ^ sub;
        arith_flags = o;
    endfunction

    logic [2:0] rf;
    logic [1:0] md;
    logic two;
    logic [2:0] alu;
    logic [7:0] cyc;
    logic known;
    logic prot_only;
    logic smm_only;
    logic smm_ok;
    logic limit_bad;
    logic [31:0] alu_res;

    always_comb
    begin
        rf = op_modrm[5:3];
        md = op_modrm[7:6];
        two = (op_byte0 == OP_TWO_BYTE);
        alu = ALU_NONE;
        cyc = CYC_ALU;
        known = 1'b1;
        prot_only = 1'b0;
        smm_only = 1'b0;
        if (two)
        begin
            if (op_byte1 == OP2_SAVE_SEG || op_byte1 == OP2_SAVE_LDT)
            begin
                cyc = CYC_SAVE;
                smm_only = 1'b1;
            end
            else if (op_byte1 == OP2_SAVE_TASK)
            begin
                cyc = CYC_SAVE_TASK;
                smm_only = 1'b1;
            end
            else if (op_byte1 == OP2_VERIFY &&
                     (rf == REG_VERIFY_RD || rf == REG_VERIFY_WR))
            begin
                cyc = CYC_VERIFY;
                prot_only = 1'b1;
            end
            else if (op_byte1 == OP2_FLUSH)
                cyc = CYC_FLUSH;
            else if (op_byte1 == OP2_MSR_WRITE)
                cyc = CYC_MSR;
            else if (op_byte1[7:1] == OP2_EXCHANGE_ADD_INSN_HI)
            begin
                alu = ALU_ADD;
                cyc = CYC_SWAP;
            end
            else
                known = 1'b0;
        end
        else if (op_byte0 == OP_SET_CARRY)
            cyc = CYC_SET_CARRY;
        else if (op_byte0 == OP_SET_DIR)
            cyc = CYC_SET_DIR;
        else if (op_byte0 == OP_SET_INT)
            cyc = CYC_SET_INT;
        else if (op_byte0 == OP_FPU_WAIT)
            cyc = CYC_WAIT;
        else if (op_byte0[7:2] == 6'h0A || op_byte0[7:1] == 7'h16)
            alu = ALU_SUB;
        else if (op_byte0[7:2] == 6'h0C || op_byte0[7:1] == 7'h1A)
            alu = ALU_XOR;
        else if (op_byte0[7:2] == 6'h20 && rf == REG_SUB)
            alu = ALU_SUB;
        else if (op_byte0[7:2] == 6'h20 && rf == REG_XOR)
            alu = ALU_XOR;
        else if (op_byte0[7:1] == 7'h42 || op_byte0[7:1] == 7'h54 ||
                 (op_byte0[7:1] == 7'h7B && rf == 3'h0))
            alu = ALU_TEST;
        else if (op_byte0[7:1] == 7'h43 || op_byte0[7:3] == 5'h12)
            cyc = CYC_SWAP;
        else
            known = 1'b0;
        smm_ok = smi_enabled && (smm_region_reg != 32'h00000000) &&
                 (current_privilege == 2'h0) &&
                 (smm_access_bit || in_smi_handler);
        limit_bad = !protected_mode && operand_is_mem &&
                    (operand_end > REAL_SEG_LIMIT);
        unique case (alu)
            ALU_SUB: alu_res = operand_a - operand_b;
            ALU_ADD: alu_res = operand_a + operand_b;
            ALU_XOR: alu_res = operand_a ^ operand_b;
            ALU_TEST: alu_res = operand_a & operand_b;
            default: alu_res = 32'h00000000;
        endcase
    end

    always_comb
    begin
        cur_next = cur_reg;
        cur_next.done = 1'b0;
        cur_next.fault = 1'b0;
        cur_next.flags_we = 1'b0;
        cur_next.res_we = 1'b0;
        cur_next.int_set = 1'b0;
        cur_next.dir_set = 1'b0;
        cur_next.msr = 1'b0;
        cur_next.save = 1'b0;
        unique case (cur_reg.st)
            ST_IDLE:
            begin
                cur_next.lock = 1'b0;
                if (issue_valid && known)
                begin
                    cur_next.flags = flags_in;
                    cur_next.cnt = cyc - 8'h01;
                    cur_next.busy = 1'b1;
                    cur_next.st = ST_RUN;
                    if (prot_only && !protected_mode)
                    begin
                        cur_next.vec = VEC_INVALID_OP;
                        cur_next.fault = 1'b1;
                    end
                    else if (smm_only && !smm_ok)
                    begin
                        cur_next.vec = VEC_INVALID_OP;
                        cur_next.fault = 1'b1;
                    end
                    else if (!two && op_byte0 == OP_SET_INT &&
                             protected_mode &&
                             current_privilege > io_privilege)
                    begin
                        cur_next.vec = VEC_GEN_PROT;
                        cur_next.fault = 1'b1;
                    end
                    else if (limit_bad)
                    begin
                        cur_next.vec = operand_on_stack ? VEC_STACK
                                                        : VEC_GEN_PROT;
                        cur_next.fault = 1'b1;
                    end
                    if (cur_next.fault)
                    begin
                        cur_next.st = ST_IDLE;
                        cur_next.busy = 1'b0;
                        cur_next.done = 1'b1;
                    end
                    else
                    begin
                        if (two)
                        begin
                            if (smm_only)
                            begin
                                cur_next.save = 1'b1;
                                cur_next.skind = op_byte1[2:1];
                            end
                            if (op_byte1 == OP2_VERIFY)
                            begin
                                cur_next.flags[FZ] = (rf == REG_VERIFY_RD)
                                    ? seg_readable : seg_writable;
                                cur_next.flags_we = 1'b1;
                            end
                            if (op_byte1 == OP2_FLUSH)
                                cur_next.flush = 1'b1;
                            if (op_byte1 == OP2_MSR_WRITE)
                                cur_next.msr = 1'b1;
                        end
                        else if (op_byte0 == OP_SET_CARRY)
                        begin
                            cur_next.flags[FC] = 1'b1;
                            cur_next.flags_we = 1'b1;
                        end
                        else if (op_byte0 == OP_SET_DIR)
                            cur_next.dir_set = 1'b1;
                        else if (op_byte0 == OP_SET_INT)
                            cur_next.int_set = 1'b1;
                        else if (op_byte0 == OP_FPU_WAIT)
                            cur_next.st = ST_WAIT_FPU;
                        else if (alu == ALU_NONE && md != MOD_REG &&
                                 op_byte0[7:1] == 7'h43)
                            cur_next.lock = 1'b1;
                        if (alu == ALU_SUB || alu == ALU_ADD)
                        begin
                            cur_next.flags = arith_flags(operand_a,
                                operand_b, alu == ALU_SUB,
                                operand_wide);
                            cur_next.flags_we = 1'b1;
                        end
                        else if (alu != ALU_NONE)
                        begin
                            cur_next.flags = logic_flags(alu_res,
                                operand_wide, flags_in);
                            cur_next.flags_we = 1'b1;
                        end
                        cur_next.res = alu_res;
                        cur_next.res_we = (alu != ALU_NONE) &&
                                          (alu != ALU_TEST);
                        if (cyc == 8'h01 && cur_next.st == ST_RUN)
                        begin
                            cur_next.st = ST_IDLE;
                            cur_next.busy = 1'b0;
                            cur_next.done = 1'b1;
                        end
                    end
                end
            end
            ST_RUN:
            begin
                if (cur_reg.cnt <= 8'h01)
                begin
                    cur_next.cnt = RST_COUNT;
                    if (cur_reg.flush)
                        cur_next.st = ST_FLUSH;
                    else
                    begin
                        cur_next.st = ST_IDLE;
                        cur_next.busy = 1'b0;
                        cur_next.done = 1'b1;
                    end
                end
                else
                    cur_next.cnt = cur_reg.cnt - 8'h01;
            end
            ST_WAIT_FPU:
            begin
                if (!fpu_busy)
                begin
                    cur_next.st = ST_IDLE;
                    cur_next.busy = 1'b0;
                    cur_next.done = 1'b1;
                end
            end
            ST_FLUSH:
            begin
                if (flush_done)
                begin
                    cur_next.flush = 1'b0;
                    cur_next.st = ST_IDLE;
                    cur_next.busy = 1'b0;
                    cur_next.done = 1'b1;
                end
            end
            default:
                cur_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            cur_reg <= '{st: ST_IDLE, cnt: RST_COUNT, vec: 8'h00,
                         res: 32'h00000000, flags: 6'h00,
                         skind: 2'h0, default: 1'b0};
        else
            cur_reg <= cur_next;
    end

    assign busy = cur_reg.busy;
    assign done = cur_reg.done;
    assign flags_out = cur_reg.flags;
    assign flags_we = cur_reg.flags_we;
    assign int_enable_set = cur_reg.int_set;
    assign direction_set = cur_reg.dir_set;
    assign result = cur_reg.res;
    assign result_we = cur_reg.res_we;
    assign fault = cur_reg.fault;
    assign fault_vector = cur_reg.vec;
    assign bus_lock = cur_reg.lock;
    assign flush_req = cur_reg.flush;
    assign msr_write = cur_reg.msr;
    assign save_req = cur_reg.save;
    assign save_kind = cur_reg.skind;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_carry;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && op_byte0 == OP_SET_CARRY) |=>
            done && flags_we && flags_out[FC] &&
            flags_out[5:1] == $past(flags_in[5:1]);
    endproperty
    a_carry: assert property (p_carry)
        else $error("set carry wrong");

    property p_dir;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && op_byte0 == OP_SET_DIR) |=>
            direction_set ##1 !done [*2] ##1 done;
    endproperty
    a_dir: assert property (p_dir)
        else $error("set direction timing wrong");

    property p_int;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && op_byte0 == OP_SET_INT &&
         !(protected_mode && current_privilege > io_privilege)) |=>
            int_enable_set ##5 done;
    endproperty
    a_int: assert property (p_int)
        else $error("set interrupt timing wrong");

    property p_int_fault;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && op_byte0 == OP_SET_INT && protected_mode &&
         current_privilege > io_privilege) |=>
            fault && fault_vector == VEC_GEN_PROT && !int_enable_set;
    endproperty
    a_int_fault: assert property (p_int_fault)
        else $error("privilege fault missing");

    property p_smm;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && two && smm_only && !smm_ok) |=>
            fault && fault_vector == VEC_INVALID_OP && !save_req;
    endproperty
    a_smm: assert property (p_smm)
        else $error("save instruction not refused");

    property p_task;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && two && op_byte1 == OP2_SAVE_TASK &&
         smm_ok && !limit_bad) |=> save_req ##20 done;
    endproperty
    a_task: assert property (p_task)
        else $error("task save timing wrong");

    property p_real_prot;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && prot_only && !protected_mode) |=>
            fault && fault_vector == VEC_INVALID_OP;
    endproperty
    a_real_prot: assert property (p_real_prot)
        else $error("protected-only not refused");

    property p_test;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && alu == ALU_TEST && !limit_bad) |=>
            done && !result_we && !flags_out[FO] && !flags_out[FC];
    endproperty
    a_test: assert property (p_test)
        else $error("test wrote result");

    property p_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && op_byte0[7:1] == 7'h43 &&
         md != MOD_REG && !limit_bad) |=> bus_lock [*2];
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock not held");

    property p_limit;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_valid && !busy && known && !prot_only && !smm_only &&
         limit_bad && !(op_byte0 == OP_SET_INT && !two && protected_mode))
        |=> fault && fault_vector == ($past(operand_on_stack) ?
                                      VEC_STACK : VEC_GEN_PROT);
    endproperty
    a_limit: assert property (p_limit)
        else $error("limit fault wrong");
endmodule

//--- verification/x86_insn_decode_tail_bench.sv
// Self-checking bench for the instruction decode tail.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module x86_insn_decode_tail_bench;
import insn_tail_pkg::*;
logic clk_sys = 1'h0, sys_rst = 1'h1, issue_valid = 1'h0, operand_wide;
logic protected_mode, smi_enabled, smm_access_bit, in_smi_handler;
logic operand_is_mem, operand_on_stack, seg_readable, seg_writable;
logic fpu_busy = 1'h0, flush_done = 1'h0, ok;
logic [7:0] op_byte0, op_byte1, op_modrm, fault_vector, fv, v;
logic [31:0] operand_a, operand_b, smm_region_reg, result, t, seed = 32'h8347;
logic [1:0] current_privilege, io_privilege, save_kind, sk;
logic [16:0] operand_end;
logic [5:0] flags_in, flags_out, fl;
logic [6:0] ev, xe;
logic busy, done, flags_we, int_enable_set, direction_set, result_we, fault;
logic bus_lock, flush_req, msr_write, save_req;
int n_errors = 0, n_tests = 0, cyc, sl = 0;
logic [31:0] tbl [15] = '{32'hF9000001, 32'hFD000004, 32'hFB000006,
    32'h2B00C001, 32'h3300C001, 32'h8500C001, 32'h8700C002, 32'h87000002,
    32'h0FC1C002, 32'h0F300001, 32'h0F780014, 32'h0F7A0014, 32'h0F7C0015,
    32'h0F00E008, 32'h0F00E808};
x86_insn_decode_tail i_x86_insn_decode_tail (.clk_sys, .sys_rst,
    .issue_valid, .op_byte0, .op_byte1, .op_modrm, .operand_a, .operand_b,
    .operand_wide, .protected_mode, .current_privilege, .io_privilege,
    .smi_enabled, .smm_region_reg, .smm_access_bit, .in_smi_handler,
    .operand_end, .operand_is_mem, .operand_on_stack, .seg_readable,
    .seg_writable, .fpu_busy, .flush_done, .flags_in, .busy, .done,
    .flags_out, .flags_we, .int_enable_set, .direction_set, .result,
    .result_we, .fault, .fault_vector, .bus_lock, .flush_req, .msr_write,
    .save_req, .save_kind);
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
function automatic logic [5:0] expf(logic [7:0] b0, logic [7:0] b1);
    logic [32:0] r;
    logic [31:0] a, b;
    logic z;
    int s;
    s = operand_wide ? 31 : 15;
    a = operand_wide ? operand_a : {16'h0, operand_a[15:0]};
    b = operand_wide ? operand_b : {16'h0, operand_b[15:0]};
    r = (b0 == 8'h2B) ? a - b : (b0 == 8'h33) ? a ^ b
        : (b0 == 8'h85) ? a & b : a + b;
    z = operand_wide ? r[31:0] == 32'h0 : r[15:0] == 16'h0;
    if (b0 == 8'hF9)
        return flags_in | 6'h01;
    if (b0 == 8'h0F && b1 == 8'h00)
        return {flags_in[5:4], op_modrm[3] ? seg_writable : seg_readable,
                flags_in[2:0]};
    if (b0 == 8'h33 || b0 == 8'h85)
        return {1'h0, r[s], z, flags_in[2], ~^r[7:0], 1'h0};
    if (b0 != 8'h2B && !(b0 == 8'h0F && b1 == 8'hC1))
        return flags_in;
    return {((b0 == 8'h2B) ^ ~(a[s] ^ b[s])) & (a[s] ^ r[s]), r[s], z,
            a[4] ^ b[4] ^ r[4], ~^r[7:0], r[s + 1]};
endfunction
task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// Issues one instruction, then watches every cycle up to done.
task automatic go(input logic [31:0] t, input logic [6:0] e,
                  input logic [7:0] v);
    logic [5:0] xf;
    logic [31:0] xr, rs;
    {op_byte0, op_byte1, op_modrm} = t[31:8];
    xf = e[6] ? flags_in : expf(t[31:24], t[23:16]);
    xr = e[6] ? 32'h0 : (t[31:24] == 8'h2B) ? operand_a - operand_b
        : (t[31:24] == 8'h33) ? operand_a ^ operand_b
        : (t[31:16] == 16'h0FC1) ? operand_a + operand_b : 32'h0;
    issue_valid = 1'h1;
    {ev, fl, fv, sk, rs} = {7'h0, flags_in, 8'h0, 2'h0, 32'h0};
    for (cyc = 1; cyc < 300; cyc++)
    begin
        @(posedge clk_sys) #1;
        issue_valid = 1'h0;
        ev |= {fault, bus_lock, flush_req, msr_write, save_req,
               int_enable_set, direction_set};
        if (flags_we === 1'h1) fl = flags_out;
        if (result_we === 1'h1) rs = result;
        if (fault === 1'h1) fv = fault_vector;
        if (save_req === 1'h1) sk = save_kind;
        if (done === 1'h1) break;
    end
    ok = cyc >= t[7:0] && cyc <= t[7:0] + sl;
    `CHK("cycles", 1'h1, ok)
    `CHK("events", e, ev)
    `CHK("flags", xf, fl)
    `CHK("vector", v, fv)
    `CHK("kind", e[2] ? t[18:17] : 2'h0, sk)
    `CHK("result", xr, rs)
    `CHK("busy", 1'h0, busy)
    $display("test %h done", t);
endtask
initial
    forever #20 clk_sys = ~clk_sys;
initial
begin
    #400000;
    n_errors++;
    summarize();
end
initial
begin
    {operand_wide, protected_mode, smm_access_bit, operand_is_mem,
     operand_on_stack, seg_readable, seg_writable, flags_in} = '0;
    {op_byte0, op_byte1, op_modrm, operand_a, operand_b, operand_end} = '0;
    {current_privilege, io_privilege, smi_enabled, in_smi_handler} = 6'h3;
    smm_region_reg = 32'h100;
    repeat (20) @(posedge clk_sys);
    #1 sys_rst = 1'h0;
    `CHK("reset", 3'h0, {busy, done, fault})
    {current_privilege, io_privilege} = 4'h0;
    for (int p = 0; p < 2; p++)
        foreach (tbl[i])
        begin
            t = tbl[i];
            operand_a = rnd();
            operand_b = rnd();
            {flags_in, operand_wide, seg_readable, seg_writable} = 9'(rnd());
            protected_mode = p == 0;
            operand_is_mem = t[31:8] == 24'h870000;
            xe = {3'h0, t[31:16] == 16'h0F30,
                  t[31:24] == 8'h0F && t[23:16] inside {8'h78, 8'h7A, 8'h7C},
                  t[31:24] == 8'hFB, t[31:24] == 8'hFD};
            xe[5] = operand_is_mem;
            v = 8'h0;
            if (p == 1 && t[31:16] == 16'h0F00)
                {t[7:0], xe, v} = {8'h01, 7'h40, VEC_INVALID_OP};
            go(t, xe, v);
        end
    protected_mode = 1'h1;
    {current_privilege, io_privilege} = 4'hD;
    go(32'hFB000001, 7'h40, VEC_GEN_PROT);
    {current_privilege, io_privilege} = 4'h5;
    go(32'hFB000006, 7'h02, 8'h0);
    for (int k = 0; k < 4; k++)
    begin
        smi_enabled = k != 0;
        smm_region_reg = (k == 1) ? 32'h0 : 32'h100;
        current_privilege = (k == 2) ? 2'h1 : 2'h0;
        in_smi_handler = k != 3;
        go(32'h0F7C0001, 7'h40, VEC_INVALID_OP);
    end
    {protected_mode, operand_is_mem, operand_end} = {2'h1, 17'h10000};
    go(32'h2B000001, 7'h40, VEC_GEN_PROT);
    operand_on_stack = 1'h1;
    go(32'h2B000001, 7'h40, VEC_STACK);
    operand_end = 17'h0FFFF;
    go(32'h2B000001, 7'h00, 8'h0);
    {operand_is_mem, fpu_busy, sl} = {2'h1, 32'd2};
    fork
        go(32'h9B00000A, 7'h00, 8'h0);
        begin
            repeat (10) @(posedge clk_sys);
            #1 fpu_busy = 1'h0;
        end
    join
    fork
        go(32'h0F09001E, 7'h10, 8'h0);
        begin
            repeat (30) @(posedge clk_sys);
            #1 flush_done = 1'h1;
            @(posedge clk_sys) #1 flush_done = 1'h0;
        end
    join
    summarize();
end
endmodule
